/* File: verilog/srap_device.sv */
/*
  device end of the serial register access port: link-side shifter on the
  serial clock, register space on the system clock.
  assumes: the host keeps chip_select_n high for at least three system
  clocks between frames and holds out_edge_select steady.
*/
`include "srap_defines.svh"

module srap_device #(
  parameter int unsigned NUM_LOC = `SRAP_NUM_LOC,
  parameter int unsigned HOLD_CYCLES = `SRAP_HOLD_CYC,
  parameter logic [7:0] CHIP_ID = 8'h5a // arbitrary value
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  srap_if.dev LINK,
  input wire logic [7:0] I_STATUS_EVENT,
  output logic O_READY,
  output logic [NUM_LOC*8-1:0] O_CONFIG,
  output logic [15:0] O_WIDE_VALUE
);

  localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);

  if (NUM_LOC > 128 || NUM_LOC <= 32'(`SRAP_WIDE_HI_ADDR) || HOLD_CYCLES < 1) begin : g_bad_param
    $error("srap_device: unsupported parameter values");
  end

  // ****************************************************************
  // link side, clocked by the serial clock
  // ****************************************************************
  logic frame_rst_n;                    // frame logic clears while deselected
  logic [4:0] cnt_q, cnt_d;             // rising edges seen in this frame
  srap_pkg::srap_addr_t addr_q, addr_d; // address shifter
  logic rw_q, rw_d;                     // 1 = read
  srap_pkg::srap_byte_t wsh_q, wsh_d;   // write data shifter
  logic rise_q, rise_d;                 // bit launched on rising edge
  logic fall_q, fall_d;                 // bit launched on falling edge
  srap_pkg::srap_addr_t acc_addr_q, acc_addr_d;
  logic acc_rw_q, acc_rw_d;
  srap_pkg::srap_byte_t acc_data_q, acc_data_d;
  logic acc_tgl_q, acc_tgl_d;           // flips once per finished frame
  srap_pkg::srap_byte_t rd_byte;        // read mux, quasi-static during a frame

  // no edges are needed outside a frame: deselect alone clears the shifter
  assign frame_rst_n = I_RST_N & ~LINK.chip_select_n;

  // shift in address, direction, data; launch read bits
  always_comb begin
    cnt_d = cnt_q;
    addr_d = addr_q;
    rw_d = rw_q;
    wsh_d = wsh_q;
    rise_d = rise_q;
    fall_d = fall_q;
    acc_addr_d = acc_addr_q;
    acc_rw_d = acc_rw_q;
    acc_data_d = acc_data_q;
    acc_tgl_d = acc_tgl_q;
    if (cnt_q < 5'(`SRAP_FRAME_BITS)) begin
      cnt_d = cnt_q + 5'd1;
    end
    if (cnt_q < 5'(`SRAP_RW_POS)) begin
      addr_d[cnt_q[2:0]] = LINK.serial_in;
    end else if (cnt_q == 5'(`SRAP_RW_POS)) begin
      rw_d = LINK.serial_in;
    end else if (cnt_q < 5'(`SRAP_FRAME_BITS)) begin
      wsh_d[cnt_q[2:0]] = LINK.serial_in;
    end
    // rising-edge launch: bit k on rise k+8, bit 0 on the same rise as the direction bit
    if (cnt_q >= 5'(`SRAP_RW_POS) && cnt_q < 5'(`SRAP_FRAME_BITS - 1)) begin
      rise_d = rd_byte[3'(cnt_q[2:0] + 3'd1)];
    end
    // falling-edge launch value, taken by the falling-edge register
    if (cnt_q[4:3] == 2'b01) begin
      fall_d = rd_byte[cnt_q[2:0]];
    end
    // last data bit: hand the whole access to the system side
    if (cnt_q == 5'(`SRAP_FRAME_BITS - 1)) begin
      acc_addr_d = addr_q;
      acc_rw_d = rw_q;
      acc_data_d = {LINK.serial_in, wsh_q[6:0]};
      acc_tgl_d = ~acc_tgl_q;
    end
  end

  // frame state registers
  always_ff @(posedge LINK.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_q <= 5'h00;
      addr_q <= 7'h00;
      rw_q <= 1'b0;
      wsh_q <= 8'h00;
      rise_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      rw_q <= rw_d;
      wsh_q <= wsh_d;
      rise_q <= rise_d;
    end
  end

  // access hand-over registers survive deselect, cleared only by reset
  always_ff @(posedge LINK.sclk or negedge I_RST_N) begin
    if (!I_RST_N) begin
      acc_addr_q <= 7'h00;
      acc_rw_q <= 1'b0;
      acc_data_q <= 8'h00;
      acc_tgl_q <= 1'b0;
    end else begin
      acc_addr_q <= acc_addr_d;
      acc_rw_q <= acc_rw_d;
      acc_data_q <= acc_data_d;
      acc_tgl_q <= acc_tgl_d;
    end
  end

  // falling-edge launch: bit k half a clock after rise k+8
  always_ff @(negedge LINK.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fall_q <= 1'b0;
    end else begin
      fall_q <= fall_d;
    end
  end

  // drive only while selected, reading, past the direction bit
  assign LINK.serial_out = LINK.out_edge_select ? fall_q : rise_q;
  assign LINK.serial_out_oe = ~LINK.chip_select_n & rw_q & (cnt_q > 5'(`SRAP_RW_POS));

  // ****************************************************************
  // system side, clocked by I_CLOCK
  // ****************************************************************
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q; // access toggle synchroniser
  logic cs_s1_q, cs_s2_q;             // deselect synchroniser
  logic acc_ev;                       // one pulse per finished frame
  logic [HW-1:0] hold_q, hold_d;      // reset stretch counter
  logic ready_q, ready_d;
  srap_pkg::srap_byte_t cfg_q [NUM_LOC];
  srap_pkg::srap_byte_t cfg_d [NUM_LOC];
  srap_pkg::srap_byte_t sts_q, sts_d, shadow_q, shadow_d;
  srap_pkg::srap_byte_t pend_q, pend_d, frz_q, frz_d;
  logic pend_v_q, pend_v_d;           // low wide byte written last
  logic [15:0] wide_q, wide_d;
  srap_pkg::srap_byte_t clr;          // status bits to clear

  assign acc_ev = tgl_s2_q ^ tgl_s3_q;

  // crossings: first stage is read by the second stage only
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
    end else begin
      tgl_s1_q <= acc_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      cs_s1_q <= LINK.chip_select_n;
      cs_s2_q <= cs_s1_q;
    end
  end

  // register space next state
  always_comb begin
    hold_d = hold_q;
    ready_d = ready_q;
    cfg_d = cfg_q;
    pend_d = pend_q;
    pend_v_d = pend_v_q;
    wide_d = wide_q;
    frz_d = frz_q;
    clr = 8'h00;
    // stay in the reset state for the hold time after release
    if (!ready_q) begin
      if (hold_q == HW'(HOLD_CYCLES - 1)) begin
        ready_d = 1'b1;
      end else begin
        hold_d = hold_q + HW'(1);
      end
    end else if (acc_ev) begin
      pend_v_d = 1'b0; // any other access breaks a wide write
      if (!acc_rw_q && 32'(acc_addr_q) < NUM_LOC) begin // undefined writes dropped
        case (acc_addr_q)
          `SRAP_ID_ADDR: begin
          end
          `SRAP_STS_ADDR: begin
            clr = acc_data_q; // write one clears, zero
          end
          `SRAP_WIDE_LO_ADDR: begin
            pend_d = acc_data_q;
            pend_v_d = 1'b1;
          end
          `SRAP_WIDE_HI_ADDR: begin
            if (pend_v_q) begin
              wide_d = {acc_data_q, pend_q}; // commit both bytes at once
              frz_d = acc_data_q;
            end
          end
          default: begin
            cfg_d[acc_addr_q] = acc_data_q; // whole byte, don't-care bits stored inert
          end
        endcase
      end else if (acc_rw_q && acc_addr_q == `SRAP_WIDE_LO_ADDR) begin
        frz_d = wide_q[15:8]; // snapshot the high byte for the next read
      end
    end
    // hardware set beats a same-cycle clear
    sts_d = ready_q ? ((sts_q & ~clr) | I_STATUS_EVENT) : `SRAP_STS_RST;
    // shadow follows status only while deselected
    shadow_d = cs_s2_q ? sts_q : shadow_q;
  end

  // register space registers, all back to defaults on reset
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      hold_q <= '0;
      ready_q <= 1'b0;
      for (int i = 0; i < NUM_LOC; i++) begin
        cfg_q[i] <= `SRAP_CFG_RST;
      end
      sts_q <= `SRAP_STS_RST;
      shadow_q <= `SRAP_STS_RST;
      pend_q <= 8'h00;
      pend_v_q <= 1'b0;
      wide_q <= `SRAP_WIDE_RST;
      frz_q <= 8'h00;
    end else begin
      hold_q <= hold_d;
      ready_q <= ready_d;
      cfg_q <= cfg_d;
      sts_q <= sts_d;
      shadow_q <= shadow_d;
      pend_q <= pend_d;
      pend_v_q <= pend_v_d;
      wide_q <= wide_d;
      frz_q <= frz_d;
    end
  end

  // read mux: sources change only between frames, so the link may read it
  always_comb begin
    rd_byte = 8'h00;
    case (addr_q)
      `SRAP_ID_ADDR: rd_byte = CHIP_ID;
      `SRAP_STS_ADDR: rd_byte = shadow_q;
      `SRAP_WIDE_LO_ADDR: rd_byte = wide_q[7:0];
      `SRAP_WIDE_HI_ADDR: rd_byte = frz_q;
      default: begin
        if (32'(addr_q) < NUM_LOC) begin
          rd_byte = cfg_q[addr_q]; // configuration reads back
        end
      end
    endcase
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  for (genvar g = 0; g < NUM_LOC; g++) begin : g_cfg_out
    assign O_CONFIG[g*8 +: 8] = cfg_q[g];
  end
  assign O_READY = ready_q;
  assign O_WIDE_VALUE = wide_q;

endmodule : srap_device

/* File: common/srap_defines.svh */
/*
  constants of the serial register access port: map offsets, reset values,
  frame layout and timing counts.
  assumes: included by bare name from the package and from both ends.
*/
`ifndef SRAP_DEFINES_SVH
`define SRAP_DEFINES_SVH

// ****************************************************************
// register space
// ****************************************************************
`define SRAP_ADDR_W 7
`define SRAP_NUM_LOC 95
`define SRAP_ID_ADDR 7'h00
`define SRAP_STS_ADDR 7'h05
`define SRAP_WIDE_LO_ADDR 7'h3c
`define SRAP_WIDE_HI_ADDR 7'h3d
`define SRAP_CFG_RST 8'h00
`define SRAP_STS_RST 8'h00
`define SRAP_WIDE_RST 16'h0000

// ****************************************************************
// frame layout: address bits, one read/write bit, data bits
// ****************************************************************
`define SRAP_RW_POS 7
`define SRAP_FRAME_BITS 16

// ****************************************************************
// timing
// ****************************************************************
`define SRAP_CLK_MHZ 40
`define SRAP_HOLD_MS 250
`define SRAP_HOLD_CYC (`SRAP_HOLD_MS * `SRAP_CLK_MHZ * 1000)
`define SRAP_HALF_CYC 2
`define SRAP_GAP_CYC 4

`endif

/* File: common/srap_pkg.sv */
/*
  types shared by the two ends of the serial register access port.
  assumes: nothing beyond the defines header.
*/
`include "srap_defines.svh"

package srap_pkg;

  // ****************************************************************
  // host sequencer states, one-hot
  // ****************************************************************
  typedef enum logic [4:0] {
    SRAP_IDLE = 5'b00001,
    SRAP_LOW  = 5'b00010,
    SRAP_HIGH = 5'b00100,
    SRAP_TAIL = 5'b01000,
    SRAP_GAP  = 5'b10000
  } srap_state_t;

  typedef logic [7:0] srap_byte_t;
  typedef logic [`SRAP_ADDR_W-1:0] srap_addr_t;

endpackage : srap_pkg

/* File: common/srap_if.sv */
/*
  the serial link between host and device.
  assumes: the device drives serial_out at all times; the bench judges driving by serial_out_oe alone.
*/
interface srap_if;
  logic sclk;            // serial clock, made by the host
  logic chip_select_n;   // frame, active low
  logic serial_in;       // host to device
  logic serial_out;      // device to host
  logic serial_out_oe;   // device drives serial_out
  logic out_edge_select; // launch edge of serial_out

  modport dev (
    input sclk,
    input chip_select_n,
    input serial_in,
    input out_edge_select,
    output serial_out,
    output serial_out_oe
  );

  modport host (
    output sclk,
    output chip_select_n,
    output serial_in,
    output out_edge_select,
    input serial_out,
    input serial_out_oe
  );
endinterface : srap_if

/* File: verilog/srap_host.sv */
/*
  host end of the serial register access port: runs one framed access per
  request, making the serial clock by dividing its own clock.
  assumes: the user holds the edge select steady and waits for the device
  to leave its reset state before the first request.
*/
`include "srap_defines.svh"

module srap_host #(
  parameter int unsigned HALF_CYCLES = `SRAP_HALF_CYC,
  parameter int unsigned GAP_CYCLES = `SRAP_GAP_CYC
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  srap_if.host LINK,
  input wire logic I_EDGE_SELECT,
  input wire logic I_START,
  input wire logic I_READ,
  input wire logic [6:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  output logic O_BUSY,
  output logic O_DONE,
  output logic [7:0] O_RDATA
);

  if (HALF_CYCLES < 1 || HALF_CYCLES > 255 || GAP_CYCLES < 3 || GAP_CYCLES > 255) begin : g_bad_param
    $error("srap_host: unsupported parameter values");
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  srap_pkg::srap_state_t st_q, st_d;
  logic [7:0] tim_q, tim_d;     // cycles in the current phase
  logic [4:0] bit_q, bit_d;     // frame bit on the wire
  logic [15:0] frm_q, frm_d;    // {data, direction, address}
  logic [7:0] rd_q, rd_d;       // captured read byte
  logic done_q, done_d;
  logic sclk_q, sclk_d;
  logic cs_n_q, cs_n_d;
  logic sdi_q, sdi_d;
  logic half_end;

  assign half_end = (tim_q == 8'(HALF_CYCLES - 1));

  // next state: sdi changes with the falling clock, device samples rising
  always_comb begin
    st_d = st_q;
    tim_d = tim_q + 8'd1;
    bit_d = bit_q;
    frm_d = frm_q;
    rd_d = rd_q;
    done_d = 1'b0;
    sclk_d = sclk_q;
    cs_n_d = cs_n_q;
    sdi_d = sdi_q;
    case (st_q)
      srap_pkg::SRAP_IDLE: begin
        tim_d = 8'h00;
        if (I_START) begin
          frm_d = {I_WDATA, I_READ, I_ADDR}; // user supplies the full byte
          cs_n_d = 1'b0;
          sdi_d = I_ADDR[0]; // least significant first
          bit_d = 5'h00;
          st_d = srap_pkg::SRAP_LOW;
        end
      end
      srap_pkg::SRAP_LOW: begin
        if (half_end) begin
          tim_d = 8'h00;
          sclk_d = 1'b1;
          st_d = srap_pkg::SRAP_HIGH;
          // falling launch: bit k leaves after rise k+8 and is caught at rise k+9
          if (frm_q[`SRAP_RW_POS] && I_EDGE_SELECT && bit_q >= 5'd8) begin
            rd_d[bit_q[2:0]] = LINK.serial_out;
          end
        end
      end
      srap_pkg::SRAP_HIGH: begin
        if (half_end) begin
          tim_d = 8'h00;
          sclk_d = 1'b0;
          // rising launch at rise k+8, captured on the falling edge after it
          if (frm_q[`SRAP_RW_POS] && !I_EDGE_SELECT && bit_q >= 5'd7 && bit_q < 5'(`SRAP_FRAME_BITS - 1)) begin
            rd_d[3'(bit_q - 5'd7)] = LINK.serial_out;
          end
          if (bit_q == 5'(`SRAP_FRAME_BITS - 1)) begin
            st_d = srap_pkg::SRAP_TAIL;
          end else begin
            bit_d = bit_q + 5'd1;
            sdi_d = frm_q[4'(bit_q + 5'd1)];
            st_d = srap_pkg::SRAP_LOW;
          end
        end
      end
      srap_pkg::SRAP_TAIL: begin
        if (half_end) begin
          tim_d = 8'h00;
          cs_n_d = 1'b1;
          done_d = 1'b1;
          st_d = srap_pkg::SRAP_GAP;
        end
      end
      srap_pkg::SRAP_GAP: begin
        // deselect long enough for the device to refresh its status shadow
        if (tim_q == 8'(GAP_CYCLES - 1)) begin
          st_d = srap_pkg::SRAP_IDLE;
        end
      end
      default: begin
        st_d = srap_pkg::SRAP_IDLE;
        cs_n_d = 1'b1;
        sclk_d = 1'b0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q <= srap_pkg::SRAP_IDLE;
      tim_q <= 8'h00;
      bit_q <= 5'h00;
      frm_q <= 16'h0000;
      rd_q <= 8'h00;
      done_q <= 1'b0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      sdi_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tim_q <= tim_d;
      bit_q <= bit_d;
      frm_q <= frm_d;
      rd_q <= rd_d;
      done_q <= done_d;
      sclk_q <= sclk_d;
      cs_n_q <= cs_n_d;
      sdi_q <= sdi_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign LINK.sclk = sclk_q;
  assign LINK.chip_select_n = cs_n_q;
  assign LINK.serial_in = sdi_q;
  assign LINK.out_edge_select = I_EDGE_SELECT;
  assign O_BUSY = (st_q != srap_pkg::SRAP_IDLE);
  assign O_DONE = done_q;
  assign O_RDATA = rd_q;

endmodule : srap_host

/* File: verification/srap_link_checker.sv */
/*
  checker for the serial link between host and device ends.
  assumes: sampled on the system clock that also divides down to sclk.
*/
module srap_link_checker (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic out_edge_select
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // helper: serial clock rises in the current frame
  // ****************************************************************
  logic [4:0] rise_q; // rises since chip select fell
  logic dir_q; // direction bit of this frame
  // cleared by chip select, since sclk stops between frames
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      rise_q <= 5'h00;
      dir_q <= 1'b0;
    end else begin
      rise_q <= rise_q + 5'h01;
      if (rise_q == 5'h07) begin // eighth rise carries direction
        dir_q <= serial_in;
      end
    end
  end
  // ****************************************************************
  // link properties
  // ****************************************************************
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_N);
  oe_idle_a: assert property (chip_select_n |-> !serial_out_oe)
    else $error("output driven outside a frame");
  oe_window_a: assert property (serial_out_oe |-> rise_q >= 5'h08 && rise_q <= 5'h10)
    else $error("output driven outside the data phase");
  oe_read_a: assert property (!chip_select_n && rise_q >= 5'h08 && dir_q |-> serial_out_oe)
    else $error("read data phase not driven");
  frame_len_a: assert property ($rose(chip_select_n) |-> $past(rise_q) == 5'h10)
    else $error("frame without sixteen clock rises");
  sclk_idle_a: assert property (chip_select_n |-> !sclk)
    else $error("serial clock runs between frames");
  launch_edge_a: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
    |-> (out_edge_select ? $fell(sclk) : $rose(sclk)))
    else $error("read bit launched on the wrong edge");
  sdi_setup_a: assert property ($rose(sclk) |-> $stable(serial_in))
    else $error("serial input moved at the sampling edge");
  cs_setup_a: assert property ($fell(chip_select_n) |-> !sclk ##1 !sclk)
    else $error("clock rose too soon after frame start");
  frame_gap_a: assert property ($rose(chip_select_n) |-> chip_select_n [*3])
    else $error("frames too close together");
endmodule : srap_link_checker

/* File: verification/tb_top.sv */
/*
  self-checking bench: host and device ends joined by the link interface.
  assumes: one system clock feeds both ends; the reset hold is shortened.
*/
`include "srap_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned HOLD = 200; // shortened reset hold, in clocks
  logic clock = 1'b0; // system clock
  logic rst_n = 1'b0; // power-on reset, active low
  logic edge_sel = 1'b0; // launch edge for reads
  logic start = 1'b0; // access request
  logic rd = 1'b0; // request is a read
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] sts_ev = 8'h00; // status events into the device
  logic busy, done, ready;
  logic [7:0] rdata;
  logic [`SRAP_NUM_LOC*8-1:0] cfg; // stored bytes seen by the device side
  logic [15:0] wide; // committed wide value
  logic [15:0] frame_q = 16'h0000; // serial input bits, first one in bit 0
  int failures = 0;
  int compares = 0;
  int cyc = 0; // free cycle count for timing the reset hold
  logic [6:0] tbl_a [3] = '{7'h01, 7'h02, 7'h5e}; // plain config places, 5e the last defined
  logic [7:0] tbl_v [3] = '{8'h5a, 8'hc3, 8'h81};
  srap_if link ();
  srap_device #(.HOLD_CYCLES(HOLD), .CHIP_ID(8'h3c)) i_srap_device ( // id value arbitrary
    .I_CLOCK(clock), .I_RST_N(rst_n), .LINK(link), .I_STATUS_EVENT(sts_ev),
    .O_READY(ready), .O_CONFIG(cfg), .O_WIDE_VALUE(wide));
  srap_host #(.HALF_CYCLES(2), .GAP_CYCLES(4)) i_srap_host (
    .I_CLOCK(clock), .I_RST_N(rst_n), .LINK(link), .I_EDGE_SELECT(edge_sel),
    .I_START(start), .I_READ(rd), .I_ADDR(addr), .I_WDATA(wdata),
    .O_BUSY(busy), .O_DONE(done), .O_RDATA(rdata));
  srap_link_checker i_srap_link_checker (
    .I_CLOCK(clock), .I_RST_N(rst_n), .sclk(link.sclk), .chip_select_n(link.chip_select_n),
    .serial_in(link.serial_in), .serial_out(link.serial_out),
    .serial_out_oe(link.serial_out_oe), .out_edge_select(link.out_edge_select));
  // ****************************************************************
  // clock, cycle count and wire capture
  // ****************************************************************
  initial begin
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
  end
  // shifts in lsb-first so a correct frame reads {data, dir, addr}
  always @(posedge link.sclk) begin
    if (!link.chip_select_n) begin
      frame_q <= {link.serial_in, frame_q[15:1]};
    end
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  // one framed access; busy is waited out under a bound
  task automatic acc(input logic r, input logic [6:0] a, input logic [7:0] d);
    int n;
    logic dn;
    n = 0;
    dn = 1'b0;
    @(posedge clock);
    #2;
    start = 1'b1;
    rd = r;
    addr = a;
    wdata = d;
    @(posedge clock);
    #2;
    start = 1'b0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clock);
      #2;
      n++;
      dn = dn | (done === 1'b1);
    end
    check({15'h0000, n < 200}, 16'h0001);
    check({15'h0000, dn}, 16'h0001);
    if (!r) begin // write frame as sent on the wire
      check(frame_q, {d, 1'b0, a});
    end
  endtask : acc
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    acc(1'b1, a, 8'h00);
    check({8'h00, rdata}, {8'h00, exp});
  endtask : rd_chk
  task automatic ev_pulse(input logic [7:0] v);
    @(posedge clock);
    #2;
    sts_ev = v;
    @(posedge clock);
    #2;
    sts_ev = 8'h00;
  endtask : ev_pulse
  // reset, one early write that must be dropped, then wait for ready
  task automatic reset_wait();
    int t0;
    rst_n = 1'b0;
    repeat (10) @(posedge clock);
    #2;
    rst_n = 1'b1;
    t0 = cyc;
    acc(1'b0, 7'h01, 8'ha5);
    check({15'h0000, ready}, 16'h0000);
    while (ready !== 1'b1 && cyc - t0 < HOLD + 20) begin
      @(posedge clock);
      #2;
    end
    check({15'h0000, (cyc - t0 >= HOLD - 1) && (cyc - t0 <= HOLD + 3)}, 16'h0001);
    check({8'h00, cfg[15:8]}, 16'h0000);
  endtask : reset_wait
  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    reset_wait();
    // whole-byte config writes, read back under both launch edges
    for (int e = 0; e < 2; e++) begin
      edge_sel = e[0]; // changed only while idle
      repeat (4) @(posedge clock);
      for (int i = 0; i < 3; i++) begin
        acc(1'b0, tbl_a[i], tbl_v[i] ^ {8{e[0]}});
        check({8'h00, cfg[int'(tbl_a[i])*8 +: 8]}, {8'h00, tbl_v[i] ^ {8{e[0]}}});
        rd_chk(tbl_a[i], tbl_v[i] ^ {8{e[0]}});
      end
    end
    // identity byte ignores writes
    acc(1'b0, 7'h00, 8'hff);
    rd_chk(7'h00, 8'h3c);
    // status: sticky, frozen during a read, cleared by ones
    ev_pulse(8'h81);
    fork
      rd_chk(7'h05, 8'h81);
      begin
        repeat (29) @(posedge clock);
        ev_pulse(8'h04);
      end
    join
    rd_chk(7'h05, 8'h85);
    acc(1'b0, 7'h05, 8'h05);
    rd_chk(7'h05, 8'h80);
    acc(1'b0, 7'h05, 8'h80);
    rd_chk(7'h05, 8'h00);
    // wide value: only an unbroken low/high pair commits
    acc(1'b0, 7'h3c, 8'h11);
    acc(1'b0, 7'h3d, 8'h22);
    check(wide, 16'h2211);
    acc(1'b0, 7'h3c, 8'h33);
    acc(1'b0, 7'h01, 8'h00);
    acc(1'b0, 7'h3d, 8'h44);
    check(wide, 16'h2211);
    acc(1'b0, 7'h3c, 8'h66);
    acc(1'b0, 7'h3d, 8'h77);
    check(wide, 16'h7766);
    rd_chk(7'h3c, 8'h66);
    rd_chk(7'h3d, 8'h77);
    // reset between clock edges clears at once
    @(posedge clock);
    #2;
    rst_n = 1'b0;
    #1;
    check({15'h0000, ready}, 16'h0000);
    check(wide, 16'h0000);
    check({8'h00, cfg[23:16]}, 16'h0000);
    reset_wait();
    rd_chk(7'h02, 8'h00);
    // host initialises its configuration again after the reset
    acc(1'b0, tbl_a[0], tbl_v[0]);
    rd_chk(tbl_a[0], tbl_v[0]);
    close_out();
  end
  // watchdog: far beyond the expected few thousand cycles
  initial begin
    #(25 * 30000);
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    close_out();
  end
endmodule : tb_top
